// *** rtl/isc_axis_cal.sv ***
// Per-axis gain and offset correction of raw samples
`timescale 1ns/1ps
`include "isc_cfg.svh"
module isc_axis_cal (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // Samples and trims, index 0 is X
    input  wire logic             sample_tick,
    input  wire logic [1:0][15:0] raw,
    input  wire logic [1:0][11:0] offset,
    input  wire logic [1:0][11:0] gain,
    output logic [1:0][15:0]      cal
);
    for (genvar a = 0; a < 2; a++) begin : g_axis
        logic signed [28:0] prod;
        logic signed [18:0] sum;
        always_comb begin
            prod = $signed(raw[a]) * $signed({1'b0, gain[a]});
            sum  = 19'(prod >>> `ISC_GAIN_SHIFT) + 19'($signed(offset[a]));
        end
        // refresh on every sample tick, saturating
        always_ff @(posedge clk_sys) begin
            if (!resetn)             cal[a] <= 16'h0000;
            else if (sample_tick) begin
                if (sum > 19'sh07FFF)       cal[a] <= 16'h7FFF;
                else if (sum < -19'sh08000) cal[a] <= 16'h8000;
                else                        cal[a] <= sum[15:0];
            end
        end
    end
endmodule : isc_axis_cal

// *** rtl/isc_cfg.svh ***
// Register map, field positions, reset values and timing of the sensor control bank
`ifndef ISC_CFG_SVH
`define ISC_CFG_SVH
// Register byte addresses (low byte at even address)
`define ISC_ADDR_X_OFS    7'h10
`define ISC_ADDR_Y_OFS    7'h12
`define ISC_ADDR_X_GAIN   7'h14
`define ISC_ADDR_Y_GAIN   7'h16
`define ISC_ADDR_CAPT_PTR 7'h2A
`define ISC_ADDR_AUX      7'h30
`define ISC_ADDR_SMPL     7'h36
`define ISC_ADDR_SLEEP    7'h3A
`define ISC_ADDR_ACTION   7'h3E
// Reset values
`define ISC_RST_OFS       12'h000
`define ISC_RST_GAIN      12'h800
`define ISC_RST_AUX       12'h000
`define ISC_RST_SMPL      8'h01
`define ISC_RST_CAPT_PTR  16'h0000
`define ISC_PTR_RELOAD    16'h0001
// Action bit positions
`define ISC_ACT_AUTONULL  0
`define ISC_ACT_RESTORE   1
`define ISC_ACT_DAC_LATCH 2
`define ISC_ACT_STORE     3
`define ISC_ACT_STAT_CLR  4
`define ISC_ACT_PEAK_CLR  5
`define ISC_ACT_CAP_COPY  6
`define ISC_ACT_SOFT_RST  7
`define ISC_ACT_BUF_CLR   8
`define ISC_ACT_FL_ERASE  9
`define ISC_ACT_PTR_RST   10
// Fields
`define ISC_SMPL_TB_BIT   7
`define ISC_GAIN_SHIFT    11
`define ISC_NULL_SHIFT    6
`define ISC_NULL_LAST     6'h3F
// Timing
`define ISC_CLK_MHZ       200
`define ISC_TB_FAST_NS    122070
`define ISC_TB_SLOW_NS    3784000
`define ISC_SLEEP_LSB_MS  500
`endif

// *** rtl/isc_pkg.sv ***
// Types shared by the sensor control bank
package isc_pkg;
    // One received serial frame
    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } isc_frame_t;
    // One-cycle action pulses toward the rest of the device
    typedef struct packed {
        logic ptr_reset;
        logic flash_erase;
        logic buf_clear;
        logic soft_reset;
        logic cap_copy;
        logic peak_clear;
        logic status_clear;
        logic flash_store;
    } isc_action_t;
    // Autonull sequencer
    typedef enum {AN_IDLE, AN_SUM} isc_null_state_t;
endpackage : isc_pkg

// *** rtl/isc_regs.sv ***
// Control-register bank of a dual-axis impact sensor behind its serial port
`timescale 1ns/1ps
`include "isc_cfg.svh"

module isc_regs #(
    parameter int unsigned TB_FAST_CYC   = `ISC_TB_FAST_NS * `ISC_CLK_MHZ / 1000,
    parameter int unsigned TB_SLOW_CYC   = `ISC_TB_SLOW_NS * `ISC_CLK_MHZ / 1000,
    parameter int unsigned SLEEP_LSB_CYC = `ISC_SLEEP_LSB_MS * `ISC_CLK_MHZ * 1000
) (
    // System clock and reset
    input  wire logic          clk_sys,
    input  wire logic          resetn,
    // Serial port
    input  wire logic          spi_sclk,
    input  wire logic          spi_cs_n,
    input  wire logic          spi_mosi,
    output logic               spi_miso,
    // Sensor samples
    input  wire logic [15:0]   raw_x,
    input  wire logic [15:0]   raw_y,
    output logic [15:0]        cal_x,
    output logic [15:0]        cal_y,
    output logic               sample_strobe,
    // Power, level output and capture pointer
    output logic               asleep,
    output logic [11:0]        dac_level,
    output logic [15:0]        capture_pointer,
    // Action pulses
    output isc_pkg::isc_action_t action
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam logic [6:0] OFS_ADDR [2]  = '{`ISC_ADDR_X_OFS, `ISC_ADDR_Y_OFS};
    localparam logic [6:0] GAIN_ADDR [2] = '{`ISC_ADDR_X_GAIN, `ISC_ADDR_Y_GAIN};

    logic                     link_rst_reg;
    isc_pkg::isc_frame_t      frame;
    logic                     frame_valid;
    logic                     wr_stb;
    logic [6:0]               waddr;
    logic [15:0]              act_hit;
    logic [15:0]              tx_word_reg;
    logic [15:0]              rdata;
    logic [1:0][11:0]         ofs_reg;
    logic [1:0][11:0]         gain_reg;
    logic [1:0][15:0]         raw_arr;
    logic [1:0][15:0]         cal_arr;
    logic signed [21:0]       sum_reg [2];
    logic [1:0][11:0]         null_val;
    logic [11:0]              aux_reg;
    logic [7:0]               smpl_reg;
    logic [7:0]               sleep_units_reg;
    logic [26:0]              sleep_sub_reg;
    logic [19:0]              base_cnt_reg;
    logic [19:0]              base_last;
    logic [6:0]               mult_cnt_reg;
    logic                     sample_tick_reg;
    isc_pkg::isc_null_state_t null_state_reg;
    logic [5:0]               null_cnt_reg;
    logic                     null_load_reg;

    // Merge one written byte into a 12-bit register
    function automatic logic [11:0] merge12(input logic [11:0] cur, input logic hi,
                                            input logic [7:0] d);
        merge12 = hi ? {d[3:0], cur[7:0]} : {cur[11:8], d};
    endfunction : merge12

    // ****************************************************************
    // Serial link and frame decode
    // ****************************************************************
    // Link-side reset, taken from a flop so the link sees a clean level
    always_ff @(posedge clk_sys) begin
        link_rst_reg <= ~resetn;
    end

    isc_spi_link u_link (
        .clk_sys     (clk_sys),
        .link_rst    (link_rst_reg),
        .tx_word     (tx_word_reg),
        .frame       (frame),
        .frame_valid (frame_valid),
        .spi_sclk    (spi_sclk),
        .spi_cs_n    (spi_cs_n),
        .spi_mosi    (spi_mosi),
        .spi_miso    (spi_miso)
    );

    // word address with byte select in bit 0
    assign wr_stb = frame_valid & frame.wr;
    assign waddr  = {frame.addr[6:1], 1'b0};

    // only bits written as one fire an action
    // action bits 11 to 15 are never used
    always_comb begin
        act_hit = 16'h0000;
        if (wr_stb && waddr == `ISC_ADDR_ACTION) begin
            act_hit = frame.addr[0] ? {frame.data, 8'h00} : {8'h00, frame.data};
        end
    end

    // ****************************************************************
    // Action pulses
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            action <= '0;
        end else begin
            action.ptr_reset    <= act_hit[`ISC_ACT_PTR_RST];
            action.flash_erase  <= act_hit[`ISC_ACT_FL_ERASE];
            action.buf_clear    <= act_hit[`ISC_ACT_BUF_CLR];
            action.soft_reset   <= act_hit[`ISC_ACT_SOFT_RST];
            action.cap_copy     <= act_hit[`ISC_ACT_CAP_COPY];
            action.peak_clear   <= act_hit[`ISC_ACT_PEAK_CLR];
            action.status_clear <= act_hit[`ISC_ACT_STAT_CLR];
            action.flash_store  <= act_hit[`ISC_ACT_STORE];
        end
    end

    // capture pointer, reload wins over a write
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            capture_pointer <= `ISC_RST_CAPT_PTR;
        end else if (act_hit[`ISC_ACT_PTR_RST]) begin
            capture_pointer <= `ISC_PTR_RELOAD;
        end else if (wr_stb && waddr == `ISC_ADDR_CAPT_PTR) begin
            if (frame.addr[0]) capture_pointer[15:8] <= frame.data;
            else               capture_pointer[7:0]  <= frame.data;
        end
    end

    // ****************************************************************
    // Calibration trims and autonull
    // ****************************************************************
    assign raw_arr[0] = raw_x;
    assign raw_arr[1] = raw_y;

    for (genvar a = 0; a < 2; a++) begin : g_trim
        logic signed [21:0] mean;
        // negated mean, clamped into the offset range
        always_comb begin
            mean = sum_reg[a] >>> `ISC_NULL_SHIFT;
            if (mean > 22'sh000800)       null_val[a] = 12'h800;
            else if (mean < -22'sh0007FF) null_val[a] = 12'h7FF;
            else                          null_val[a] = 12'(-mean);
        end

        always_ff @(posedge clk_sys) begin
            if (!resetn || act_hit[`ISC_ACT_RESTORE]) begin
                ofs_reg[a]  <= `ISC_RST_OFS;
                gain_reg[a] <= `ISC_RST_GAIN;
            end else if (null_load_reg) begin
                ofs_reg[a] <= null_val[a];
            end else if (wr_stb && waddr == OFS_ADDR[a]) begin
                ofs_reg[a] <= merge12(ofs_reg[a], frame.addr[0], frame.data);
            end else if (wr_stb && waddr == GAIN_ADDR[a]) begin
                gain_reg[a] <= merge12(gain_reg[a], frame.addr[0], frame.data);
            end
        end

        always_ff @(posedge clk_sys) begin
            if (!resetn) begin
                sum_reg[a] <= 22'sh000000;
            end else if (null_state_reg == isc_pkg::AN_IDLE) begin
                sum_reg[a] <= 22'sh000000;
            end else if (sample_tick_reg) begin
                sum_reg[a] <= sum_reg[a] + 22'($signed(raw_arr[a]));
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            null_state_reg <= isc_pkg::AN_IDLE;
            null_cnt_reg   <= 6'h00;
            null_load_reg  <= 1'b0;
        end else begin
            null_load_reg <= 1'b0;
            case (null_state_reg)
                isc_pkg::AN_IDLE: begin
                    null_cnt_reg <= 6'h00;
                    if (act_hit[`ISC_ACT_AUTONULL]) null_state_reg <= isc_pkg::AN_SUM;
                end
                isc_pkg::AN_SUM: begin
                    if (sample_tick_reg) begin
                        null_cnt_reg <= null_cnt_reg + 6'h01;
                        if (null_cnt_reg == `ISC_NULL_LAST) begin
                            null_state_reg <= isc_pkg::AN_IDLE;
                            null_load_reg  <= 1'b1;
                        end
                    end
                end
                default: null_state_reg <= isc_pkg::AN_IDLE;
            endcase
        end
    end

    isc_axis_cal u_cal (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .sample_tick (sample_tick_reg),
        .raw         (raw_arr),
        .offset      (ofs_reg),
        .gain        (gain_reg),
        .cal         (cal_arr)
    );
    assign cal_x = cal_arr[0];
    assign cal_y = cal_arr[1];

    // ****************************************************************
    // Sample period generator
    // ****************************************************************
    // interval register, only the low byte is stored
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            smpl_reg <= `ISC_RST_SMPL;
        end else if (wr_stb && waddr == `ISC_ADDR_SMPL && !frame.addr[0]) begin
            smpl_reg <= frame.data;
        end
    end

    assign base_last = smpl_reg[`ISC_SMPL_TB_BIT] ? 20'(TB_SLOW_CYC - 1)
                                                  : 20'(TB_FAST_CYC - 1);

    // base ticks times multiplier plus one, held while asleep
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            base_cnt_reg    <= 20'h00000;
            mult_cnt_reg    <= 7'h00;
            sample_tick_reg <= 1'b0;
        end else begin
            sample_tick_reg <= 1'b0;
            if (sleep_units_reg == 8'h00) begin
                if (base_cnt_reg >= base_last) begin
                    base_cnt_reg <= 20'h00000;
                    if (mult_cnt_reg >= smpl_reg[6:0]) begin
                        mult_cnt_reg    <= 7'h00;
                        sample_tick_reg <= 1'b1;
                    end else begin
                        mult_cnt_reg <= mult_cnt_reg + 7'h01;
                    end
                end else begin
                    base_cnt_reg <= base_cnt_reg + 20'h00001;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) sample_strobe <= 1'b0;
        else         sample_strobe <= sample_tick_reg;
    end

    // ****************************************************************
    // Sleep counter
    // ****************************************************************
    // low byte sets half-second units, count down to wake
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sleep_units_reg <= 8'h00;
            sleep_sub_reg   <= 27'h0000000;
        end else if (wr_stb && waddr == `ISC_ADDR_SLEEP && !frame.addr[0]) begin
            sleep_units_reg <= frame.data;
            sleep_sub_reg   <= 27'h0000000;
        end else if (sleep_units_reg != 8'h00) begin
            if (sleep_sub_reg >= 27'(SLEEP_LSB_CYC - 1)) begin
                sleep_sub_reg   <= 27'h0000000;
                sleep_units_reg <= sleep_units_reg - 8'h01;
            end else begin
                sleep_sub_reg <= sleep_sub_reg + 27'h0000001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) asleep <= 1'b0;
        else         asleep <= (sleep_units_reg != 8'h00);
    end

    // ****************************************************************
    // Auxiliary level code
    // ****************************************************************
    // twelve-bit code written byte by byte
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            aux_reg <= `ISC_RST_AUX;
        end else if (wr_stb && waddr == `ISC_ADDR_AUX) begin
            aux_reg <= merge12(aux_reg, frame.addr[0], frame.data);
        end
    end

    // output changes only on the latch action
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            dac_level <= `ISC_RST_AUX;
        end else if (act_hit[`ISC_ACT_DAC_LATCH]) begin
            dac_level <= aux_reg;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // write-only and unmapped words read zero
    always_comb begin
        case ({frame.addr[6:1], 1'b0})
            `ISC_ADDR_X_OFS:    rdata = {4'h0, ofs_reg[0]};
            `ISC_ADDR_Y_OFS:    rdata = {4'h0, ofs_reg[1]};
            `ISC_ADDR_X_GAIN:   rdata = {4'h0, gain_reg[0]};
            `ISC_ADDR_Y_GAIN:   rdata = {4'h0, gain_reg[1]};
            `ISC_ADDR_CAPT_PTR: rdata = capture_pointer;
            `ISC_ADDR_AUX:      rdata = {4'h0, aux_reg};
            `ISC_ADDR_SMPL:     rdata = {8'h00, smpl_reg};
            default:            rdata = 16'h0000;
        endcase
    end

    // Read frame stages the word shifted out in the next frame
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            tx_word_reg <= 16'h0000;
        end else if (frame_valid && !frame.wr) begin
            tx_word_reg <= rdata;
        end
    end
endmodule : isc_regs

// *** rtl/isc_spi_link.sv ***
// Serial slave on the link clock with a toggle crossing into the system clock
`timescale 1ns/1ps
module isc_spi_link (
    // System side
    input  wire logic          clk_sys,
    input  wire logic          link_rst,
    input  wire logic [15:0]   tx_word,
    output isc_pkg::isc_frame_t frame,
    output logic               frame_valid,
    // Link side
    input  wire logic          spi_sclk,
    input  wire logic          spi_cs_n,
    input  wire logic          spi_mosi,
    output logic               spi_miso
);
    logic [3:0]  bit_cnt;
    logic [14:0] shift_reg;
    logic [15:0] rx_word;
    logic        rx_toggle;
    logic        sync1, sync2, sync3;

    // Bit counter, cleared while chip select is idle
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) bit_cnt <= 4'h0;
        else          bit_cnt <= bit_cnt + 4'h1;
    end

    // Shift in on rising edge
    always_ff @(posedge spi_sclk) begin
        shift_reg <= {shift_reg[13:0], spi_mosi};
    end

    // Whole word captured on sixteenth bit, toggle announces it
    always_ff @(posedge spi_sclk or posedge link_rst) begin
        if (link_rst) begin
            rx_word   <= 16'h0000;
            rx_toggle <= 1'b0;
        end else if (bit_cnt == 4'hF) begin
            rx_word   <= {shift_reg, spi_mosi};
            rx_toggle <= ~rx_toggle;
        end
    end

    // Shift out on falling edge, MSB first
    always_ff @(negedge spi_sclk or posedge link_rst) begin
        if (link_rst) spi_miso <= 1'b0;
        else          spi_miso <= tx_word[~bit_cnt];
    end

    // Toggle synchroniser; rx_word is stable long after the toggle
    always_ff @(posedge clk_sys) begin
        sync1       <= rx_toggle;
        sync2       <= sync1;
        sync3       <= sync2;
        frame_valid <= sync2 ^ sync3;
        if (sync2 ^ sync3) frame <= rx_word;
    end
endmodule : isc_spi_link

// *** test/isc_regs_monitor.sv ***
// Port checker of the sensor control bank
`timescale 1ns/1ps
module isc_regs_monitor #(
    parameter int unsigned TB_FAST_CYC   = 8,
    parameter int unsigned TB_SLOW_CYC   = 20,
    parameter int unsigned SLEEP_LSB_CYC = 50
) (
    // Clock and reset
    input wire logic            clk_sys,
    input wire logic            resetn,
    // Watched outputs
    input wire logic [15:0]     cal_x,
    input wire logic [15:0]     cal_y,
    input wire logic            sample_strobe,
    input wire logic            asleep,
    input wire logic [11:0]     dac_level,
    input wire logic [15:0]     capture_pointer,
    input isc_pkg::isc_action_t action
);
    // ****************
    // Helper counters
    // ****************
    logic [15:0] gap_cnt;
    logic [15:0] nap_cnt;
    // Cycles since the last tick, cycles spent asleep
    always_ff @(posedge clk_sys) begin
        gap_cnt <= (!resetn || sample_strobe || asleep) ? 16'h0000 : gap_cnt + 16'h0001;
        nap_cnt <= (!resetn || !asleep) ? 16'h0000 : nap_cnt + 16'h0001;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    property p_act_pulse;
        action != '0 |=> action == '0;
    endproperty
    a_act_pulse: assert property (p_act_pulse) else $error("action pulse too long");
    property p_ptr_reload;
        action.ptr_reset |-> ##[0:1] capture_pointer == 16'h0001;
    endproperty
    a_ptr_reload: assert property (p_ptr_reload) else $error("pointer not one");
    property p_tick_pulse;
        sample_strobe |=> !sample_strobe;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
    property p_cal_on_tick;
        ($changed(cal_x) || $changed(cal_y)) |-> sample_strobe;
    endproperty
    a_cal_on_tick: assert property (p_cal_on_tick) else $error("output moved off tick");
    property p_sleep_halt;
        asleep && $past(asleep) |-> !sample_strobe;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) else $error("tick while asleep");
    property p_sleep_len;
        nap_cnt <= 255 * SLEEP_LSB_CYC + 1;
    endproperty
    a_sleep_len: assert property (p_sleep_len) else $error("sleep too long");
    property p_tick_alive;
        gap_cnt <= 128 * TB_SLOW_CYC + 2;
    endproperty
    a_tick_alive: assert property (p_tick_alive) else $error("sampling stalled");
    property p_rst_outs;
        disable iff (1'b0) !resetn |=> action == '0 && dac_level == 12'h000;
    endproperty
    a_rst_outs: assert property (p_rst_outs) else $error("outputs not cleared");
endmodule : isc_regs_monitor

// *** test/isc_regs_tb.sv ***
// Self-checking bench of the sensor control bank
`timescale 1ns/1ps
module isc_regs_tb;
    logic clk_sys, resetn, spi_sclk, spi_cs_n, spi_mosi, spi_miso, sample_strobe, asleep;
    logic [15:0] raw_x, raw_y, cal_x, cal_y, capture_pointer, rd_w;
    logic [11:0] dac_level;
    logic [7:0]  seen;
    isc_pkg::isc_action_t action;
    int err_total, checks;
    // 200 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    isc_regs #(.TB_FAST_CYC(8), .TB_SLOW_CYC(20), .SLEEP_LSB_CYC(50)) i_isc_regs (
        .clk_sys(clk_sys), .resetn(resetn), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .raw_x(raw_x), .raw_y(raw_y),
        .cal_x(cal_x), .cal_y(cal_y), .sample_strobe(sample_strobe), .asleep(asleep),
        .dac_level(dac_level), .capture_pointer(capture_pointer), .action(action));
    isc_spi_host i_isc_spi_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso));
    // Sticky record of action pulses
    always @(posedge clk_sys) seen <= seen | action;
    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic frame(input logic [15:0] w);
        i_isc_spi_host.xfer(w, rd_w);
        repeat (20) @(negedge clk_sys);
    endtask : frame
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        frame({1'b1, a, d});
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        frame({1'b0, a, 8'h00});
        frame(16'h0000);
        chk(rd_w, exp);
    endtask : rd
    // Wait for a tick, count cycles until it
    task automatic tick(output int c);
        c = 0;
        while (sample_strobe !== 1'b1 && c < 3000) begin
            @(negedge clk_sys);
            c++;
        end
        // A missing tick is a mismatch of its own
        if (c >= 3000) begin
            err_total++;
            $display("[FAIL] %0t no sample tick", $time);
        end
        @(negedge clk_sys);
    endtask : tick
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        rd(7'h10, 16'h0000);
        rd(7'h16, 16'h0800);
        rd(7'h36, 16'h0001);
        rd(7'h30, 16'h0000);
        rd(7'h3E, 16'h0000);
    endtask : t_reset
    task automatic t_cal();
        int c;
        wr(7'h10, 8'h34);
        wr(7'h11, 8'h75);
        rd(7'h10, 16'h0534);
        wr(7'h10, 8'h10);
        wr(7'h11, 8'h00);
        wr(7'h14, 8'h00);
        wr(7'h15, 8'h04);
        raw_x = 16'd200;
        raw_y = 16'hFF38;
        tick(c);
        tick(c);
        chk(cal_x, 16'h0074);
        chk(cal_y, 16'hFF38);
        wr(7'h3E, 8'h02);
        rd(7'h10, 16'h0000);
        rd(7'h14, 16'h0800);
    endtask : t_cal
    task automatic t_dac();
        wr(7'h30, 8'h34);
        wr(7'h31, 8'hF2);
        chk(16'(dac_level), 16'h0000);
        rd(7'h30, 16'h0234);
        wr(7'h3E, 8'h04);
        chk(16'(dac_level), 16'h0234);
    endtask : t_dac
    task automatic t_act();
        wr(7'h2A, 8'h05);
        wr(7'h2B, 8'h12);
        rd(7'h2B, 16'h1205);
        chk(capture_pointer, 16'h1205);
        for (int k = 3; k <= 10; k++) begin
            seen = 8'h00;
            wr(k < 8 ? 7'h3E : 7'h3F, 8'(1 << (k % 8)));
            chk(16'(seen), 16'(1 << (k - 3)));
        end
        chk(capture_pointer, 16'h0001);
        seen = 8'h00;
        wr(7'h3F, 8'hF8);
        wr(7'h3E, 8'h00);
        chk(16'(seen), 16'h0000);
    endtask : t_act
    task automatic t_period();
        int c;
        logic [7:0] cfg [3] = '{8'h81, 8'h03, 8'h01};
        foreach (cfg[i]) begin
            wr(7'h36, cfg[i]);
            tick(c);
            tick(c);
            chk(16'(c + 1), 16'((cfg[i][7] ? 20 : 8) * (cfg[i][6:0] + 1)));
        end
        wr(7'h37, 8'h85);
        rd(7'h36, 16'h0001);
        rd(7'h3A, 16'h0000);
    endtask : t_period
    task automatic t_sleep();
        int c;
        i_isc_spi_host.xfer({1'b1, 7'h3A, 8'h02}, rd_w);
        c = 0;
        while (asleep !== 1'b1 && c < 50) begin
            @(negedge clk_sys);
            c++;
        end
        c = 0;
        while (asleep === 1'b1 && c < 400) begin
            @(negedge clk_sys);
            c++;
        end
        chk(16'(c > 97 && c < 103), 16'h0001);
        repeat (20) @(negedge clk_sys);
    endtask : t_sleep
    task automatic t_null();
        int c;
        raw_x = 16'h0040;
        raw_y = 16'hFFE0;
        wr(7'h3E, 8'h01);
        repeat (68) tick(c);
        chk(cal_x, 16'h0000);
        chk(cal_y, 16'h0000);
    endtask : t_null
    // Main sequence
    initial begin
        resetn = 1'b0;
        raw_x = 16'h0000;
        raw_y = 16'h0000;
        seen = 8'h00;
        err_total = 0;
        checks = 0;
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_reset();
        t_cal();
        t_dac();
        t_act();
        t_period();
        t_sleep();
        t_null();
        end_sim();
    end
    // Watchdog
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule : isc_regs_tb
bind isc_regs isc_regs_monitor #(.TB_FAST_CYC(TB_FAST_CYC), .TB_SLOW_CYC(TB_SLOW_CYC),
    .SLEEP_LSB_CYC(SLEEP_LSB_CYC)) i_isc_regs_monitor (.clk_sys(clk_sys), .resetn(resetn),
    .cal_x(cal_x), .cal_y(cal_y), .sample_strobe(sample_strobe), .asleep(asleep),
    .dac_level(dac_level), .capture_pointer(capture_pointer), .action(action));

// *** test/isc_spi_host.sv ***
// Host model driving mode 3 serial frames
`timescale 1ns/1ps
module isc_spi_host (
    // Serial lines
    output logic     spi_sclk,
    output logic     spi_cs_n,
    output logic     spi_mosi,
    input wire logic spi_miso
);
    // Idle link: clock high and still
    initial begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // fixed link rate, time bases shortened to match
    // One 16-bit frame, MSB first, 6 ns link clock
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        spi_cs_n = 1'b0;
        #3;
        for (int i = 15; i >= 0; i--) begin
            spi_sclk = 1'b0;
            spi_mosi = w[i];
            #3;
            spi_sclk = 1'b1;
            r[i] = spi_miso;
            #3;
        end
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi; // Released line shows no stale bit
    endtask : xfer
endmodule : isc_spi_host
